// ==== rtl/pdt_pkg.sv ====
// Package for the dead-time output interlock: widths, positions, resets.
// Assumes a single 50 MHz clock domain and synchronous active-high reset.
package pdt_pkg;

  localparam int PHASES = 3;
  localparam int DT_STAGES = 15;
  localparam int DT_W = 4;
  localparam int DIV_W = 3;

  // Delay clock dividers: even divider settings use 4, odd ones use 6
  localparam logic [2:0] DIV_FAST = 3'h4;
  localparam logic [2:0] DIV_SLOW = 3'h6;
  localparam int DIV_SEL_BIT = 0;

  // Register address of the dead-time control register on the data bus
  localparam logic [2:0] ADDR_DEAD_TIME = 3'h3;
  localparam logic [2:0] ADDR_DIVIDER = 3'h4;

  localparam logic [DT_W-1:0] DT_RESET = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
  localparam logic [2:0] PRESC_RESET = 3'h0;

  // Register write port from the processor bus
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] addr;
    logic ale;
    logic wr_n;
  } pdt_bus_t;

  // One complementary output pair, both active low
  typedef struct packed {
    logic normal_n;
    logic inverted_n;
  } pdt_pair_t;

endpackage

// ==== rtl/pdt_delay_line.sv ====
// One phase's 15-stage delay line with a tap after every stage.
// Assumes shift_en pulses once per delay-clock period.
module pdt_delay_line
  import pdt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic shift_en,
  input wire logic pwm_in,
  input wire logic [pdt_pkg::DT_W-1:0] dead_time,
  output logic delayed
);

  logic [DT_STAGES-1:0] sr_q;
  logic [DT_STAGES-1:0] sr_d;
  logic [DT_STAGES:0] taps;

  assign sr_d = {sr_q[DT_STAGES-2:0], pwm_in};
  // Tap 0 is the undelayed source so zero dead time adds nothing
  assign taps = {sr_q, pwm_in}; // [RULE1]
  assign delayed = taps[dead_time]; // [RULE4] [RULE5]

  always_ff @(posedge mclk)
  begin
    if (reset)
      sr_q <= '0;
    else if (shift_en)
      sr_q <= sr_d; // [RULE1]
  end

endmodule // pdt_delay_line

// ==== rtl/pdt_interlock.sv ====
// Dead-time output stage with inhibit and status hold interlock.
// Assumes the pulse-width signals and all control pins are synchronous
// to mclk; bus strobes are sampled as levels and edges found here.
////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Fifteen-stage tapped shift register delays pulse signal
// RULE2: Shift clock is oscillator divided four or six
// RULE3: Even divider values four, odd values six
// RULE4: Dead time zero to fifteen, zero none
// RULE5: Dead time equals setting times delay period
// RULE6: Zero dead time gives exact complementary outputs
// RULE7: Outputs active low; high means switch off
// RULE8: Only falling edges delayed; pair never both low
// RULE9: Inhibit high forces all six outputs high
// RULE10: Processor holds inhibit high until initialised
// RULE11: Hold-set pulse latches outputs forced high
// RULE12: Status output high while hold is active
// RULE13: Hold-clear pulse releases hold flipflop
// RULE14: Address latched on ALE fall, data on WR rise
// RULE15: Set wins when set and clear coincide
module pdt_interlock
  import pdt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire pdt_pkg::pdt_bus_t bus,
  input wire logic [pdt_pkg::PHASES-1:0] pwm,
  input wire logic inhibit,
  input wire logic hold_set,
  input wire logic hold_clear,
  output logic status,
  output pdt_pkg::pdt_pair_t [pdt_pkg::PHASES-1:0] phase_out,
  output logic [pdt_pkg::DT_W-1:0] dead_time,
  output logic [pdt_pkg::DIV_W-1:0] divider
);

  function automatic logic [2:0] div_ratio(input logic [DIV_W-1:0] v);
    return v[DIV_SEL_BIT] ? DIV_SLOW : DIV_FAST;
  endfunction

  logic ale_q;
  logic wr_n_q;
  logic [2:0] addr_q;
  logic [DT_W-1:0] dt_q;
  logic [DIV_W-1:0] div_q;
  logic [2:0] presc_q;
  logic [2:0] presc_d;
  logic hold_q;
  logic hold_d;
  logic [PHASES-1:0] delayed;
  logic [PHASES-1:0] ndelayed;
  logic [PHASES-1:0] pwm_n;
  pdt_pair_t [PHASES-1:0] out_d;
  pdt_pair_t [PHASES-1:0] out_q;

  wire ale_fall = ale_q & ~bus.ale;
  wire wr_rise = ~wr_n_q & bus.wr_n;
  wire [2:0] ratio = div_ratio(div_q); // [RULE3]
  wire shift_en = (presc_q == ratio - 3'h1); // [RULE2]
  wire force_off = inhibit | hold_q;

  ////////////////////////////////////////////////////////////////////
  // Bus write port

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ale_q <= 1'b0;
      wr_n_q <= 1'b1;
      addr_q <= 3'h0;
      dt_q <= DT_RESET;
      div_q <= DIV_RESET;
    end
    else
    begin
      ale_q <= bus.ale;
      wr_n_q <= bus.wr_n;
      if (ale_fall)
        addr_q <= bus.addr; // [RULE14]
      if (wr_rise && addr_q == ADDR_DEAD_TIME)
        dt_q <= bus.data[DT_W-1:0]; // [RULE14] [RULE4]
      if (wr_rise && addr_q == ADDR_DIVIDER)
        div_q <= bus.data[DIV_W-1:0];
    end
  end

  assign dead_time = dt_q;
  assign divider = div_q;

  ////////////////////////////////////////////////////////////////////
  // Delay clock prescaler

  assign presc_d = shift_en ? PRESC_RESET : presc_q + 3'h1;

  always_ff @(posedge mclk)
  begin
    if (reset)
      presc_q <= PRESC_RESET;
    else
      presc_q <= presc_d; // [RULE2]
  end

  ////////////////////////////////////////////////////////////////////
  // Delay lines: one for the pulse and one for its complement

  assign pwm_n = ~pwm;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_phase
      pdt_delay_line u_norm (
        .mclk(mclk),
        .reset(reset),
        .shift_en(shift_en),
        .pwm_in(pwm[g]),
        .dead_time(dt_q),
        .delayed(delayed[g])
      );
      pdt_delay_line u_inv (
        .mclk(mclk),
        .reset(reset),
        .shift_en(shift_en),
        .pwm_in(pwm_n[g]),
        .dead_time(dt_q),
        .delayed(ndelayed[g])
      );
      // Activation needs both the live and the delayed level, so a
      // release is immediate and an activation waits the dead time.
      assign out_d[g].normal_n =
        force_off | ~(pwm[g] & delayed[g]); // [RULE7] [RULE8] [RULE9]
      assign out_d[g].inverted_n =
        force_off | ~(pwm_n[g] & ndelayed[g]); // [RULE6] [RULE8]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Hold flipflop and output register

  // Set has priority so a fault report never gets dropped by a clear
  assign hold_d = hold_set ? 1'b1 : (hold_clear ? 1'b0 : hold_q);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hold_q <= 1'b0;
      out_q <= '1;
    end
    else
    begin
      hold_q <= hold_d; // [RULE11] [RULE13] [RULE15]
      out_q <= out_d;
    end
  end

  assign status = hold_q; // [RULE12]
  assign phase_out = out_q;

  ////////////////////////////////////////////////////////////////////
  // Checks

  for (genvar p = 0; p < PHASES; p++)
  begin : g_chk
    chk_pair_never_low: assert property ( // [RULE8]
      @(posedge mclk) disable iff (reset)
      out_q[p].normal_n | out_q[p].inverted_n)
      else $error("both outputs of a pair active");
    chk_zero_dt_compl: assert property ( // [RULE6]
      @(posedge mclk) disable iff (reset)
      // Outputs lag the settings by one register stage
      ($past(dt_q) == 4'h0 && !$past(force_off) && !$past(reset)) |->
        out_q[p].inverted_n == ~out_q[p].normal_n)
      else $error("zero dead time outputs not complementary");
    chk_release_normal: assert property ( // [RULE8]
      @(posedge mclk) disable iff (reset)
      !pwm[p] |=> out_q[p].normal_n)
      else $error("normal output release was delayed");
    chk_release_inverted: assert property ( // [RULE8]
      @(posedge mclk) disable iff (reset)
      pwm[p] |=> out_q[p].inverted_n)
      else $error("inverted output release was delayed");
  end

  chk_inhibit_forces: assert property ( // [RULE9]
    @(posedge mclk) disable iff (reset)
    inhibit |=> phase_out == '1)
    else $error("inhibit did not force outputs high");
  chk_hold_sets: assert property ( // [RULE11]
    @(posedge mclk) disable iff (reset)
    hold_set |=> status ##1 phase_out == '1)
    else $error("hold set did not force outputs");
  chk_hold_clears: assert property ( // [RULE13]
    @(posedge mclk) disable iff (reset)
    (hold_clear && !hold_set) |=> !status)
    else $error("hold clear did not release");
  chk_set_wins: assert property ( // [RULE15]
    @(posedge mclk) disable iff (reset)
    (hold_set && hold_clear) |=> status)
    else $error("clear beat set");
  chk_hold_sticks: assert property ( // [RULE12]
    @(posedge mclk) disable iff (reset)
    (status && !hold_clear) |=> status)
    else $error("status dropped without clear");
  // A divider write inside the window changes the ratio mid-count, so it is left out
  chk_div_period: assert property ( // [RULE3]
    @(posedge mclk) disable iff (reset)
    (shift_en && !div_q[DIV_SEL_BIT]) ##1 (!div_q[DIV_SEL_BIT])[*4]
      |-> shift_en)
    else $error("divide by four period wrong");
  chk_div_six: assert property ( // [RULE3]
    @(posedge mclk) disable iff (reset)
    (shift_en && div_q[DIV_SEL_BIT]) ##1 (div_q[DIV_SEL_BIT])[*6]
      |-> shift_en)
    else $error("divide by six period wrong");
  chk_dt_load: assert property ( // [RULE14]
    @(posedge mclk) disable iff (reset)
    (wr_rise && addr_q == ADDR_DEAD_TIME) |=>
      dt_q == $past(bus.data[DT_W-1:0]))
    else $error("dead time not loaded");
  chk_dt_ignore: assert property ( // [RULE14]
    @(posedge mclk) disable iff (reset)
    (wr_rise && addr_q != ADDR_DEAD_TIME) |=> $stable(dt_q))
    else $error("dead time changed by another address");
  chk_div_load: assert property ( // [RULE2]
    @(posedge mclk) disable iff (reset)
    (wr_rise && addr_q == ADDR_DIVIDER) |=>
      div_q == $past(bus.data[DIV_W-1:0]))
    else $error("divider not loaded");

endmodule // pdt_interlock

// ==== dv/pdt_bridge_model.sv ====
// Power-stage model on the far side of the six drive lines.
// Assumes active-low drives sampled on mclk; counts shoot-through cycles.
module pdt_bridge_model
  import pdt_pkg::*;
(
  input wire logic mclk,
  input wire pdt_pkg::pdt_pair_t [pdt_pkg::PHASES-1:0] drive,
  output int shoots
);
  int shoot_q = 0;
  assign shoots = shoot_q;
  // Both switches of one leg on is a short across the supply.
  // Sampled on the falling edge, where the registered drives have settled.
  always @(negedge mclk)
  begin
    for (int p = 0; p < PHASES; p++)
      if (drive[p] === 2'b00)
        shoot_q++;
  end
endmodule // pdt_bridge_model

// ==== dv/tb.sv ====
// Self-checking bench for the dead-time output interlock.
// Assumes a 50 MHz mclk; inputs move 2 ns after each rising edge.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pdt_pkg::*;
  logic mclk = 0;
  logic reset = 1;
  logic inhibit = 1;
  logic hold_set = 0;
  logic hold_clear = 0;
  logic [2:0] pwm = 3'h0;
  pdt_bus_t bus = '{8'h00, 3'h0, 1'b0, 1'b1};
  logic status;
  pdt_pair_t [PHASES-1:0] phase_out;
  logic [DT_W-1:0] dead_time;
  logic [DIV_W-1:0] divider;
  int shoots;
  int miscompares = 0;
  int checks = 0;
  always #10 mclk = ~mclk;
  pdt_interlock i_dut (.mclk(mclk), .reset(reset), .bus(bus), .pwm(pwm),
    .inhibit(inhibit), .hold_set(hold_set), .hold_clear(hold_clear),
    .status(status), .phase_out(phase_out), .dead_time(dead_time),
    .divider(divider));
  pdt_bridge_model i_bridge (.mclk(mclk), .drive(phase_out),
    .shoots(shoots));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    bus.ale = 1'b1;
    bus.addr = a;
    cyc(1);
    bus.ale = 1'b0;
    cyc(1);
    bus.wr_n = 1'b0;
    bus.data = d;
    cyc(1);
    bus.wr_n = 1'b1;
    cyc(3);
  endtask
  function automatic logic [7:0] pat(logic [2:0] w);
    pat = 8'h00;
    for (int p = 0; p < PHASES; p++)
      pat[2*p+1 -: 2] = {~w[p], w[p]};
  endfunction
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(3'h3, 8'h1f);
    chk(dead_time, 8'h0f);
    wr(3'h2, 8'h05);
    chk(dead_time, 8'h0f);
    wr(3'h4, 8'h07);
    chk(divider, 8'h07);
  endtask
  task automatic t_zero();
    wr(3'h3, 8'h00);
    for (int w = 0; w < 8; w++)
    begin
      pwm = w[2:0];
      cyc(2);
      chk({2'h0, phase_out}, pat(w[2:0]));
    end
  endtask
  task automatic t_inh_hold();
    pwm = 3'h5;
    inhibit = 1'b1;
    cyc(2);
    chk({2'h0, phase_out}, 8'h3f);
    inhibit = 1'b0;
    cyc(2);
    chk({2'h0, phase_out}, pat(3'h5));
    hold_set = 1'b1;
    cyc(1);
    hold_set = 1'b0;
    cyc(2);
    chk(status, 8'h01);
    chk({2'h0, phase_out}, 8'h3f);
    hold_set = 1'b1;
    hold_clear = 1'b1;
    cyc(1);
    hold_set = 1'b0;
    hold_clear = 1'b0;
    cyc(2);
    chk({status, 1'b0, phase_out}, 8'hbf);
    hold_clear = 1'b1;
    cyc(1);
    hold_clear = 1'b0;
    cyc(2);
    chk(status, 8'h00);
    chk({2'h0, phase_out}, pat(3'h5));
  endtask
  // Even and odd settings alike; step jitter of one delay-clock period is tolerated
  task automatic t_dead();
    int r;
    int t;
    int n;
    for (int d = 0; d < 8; d++)
    begin
      r = d[0] ? 6 : 4;
      t = d < 2 ? 1 : 15;
      pwm = 3'h0;
      wr(3'h4, 8'(d));
      wr(3'h3, 8'(t));
      cyc(100);
      pwm = 3'h7;
      n = 0;
      while (phase_out[0].normal_n !== 1'b0 && n < 200)
      begin
        cyc(1);
        n++;
      end
      chk(8'(n >= t*r-r+2 && n <= t*r+1), 8'h01);
      if (n == 200)
        finish_test();
      pwm = 3'h0;
      cyc(1);
      chk(phase_out[0].normal_n, 8'h01);
      chk(phase_out[0].inverted_n, 8'h01);
      cyc(100);
    end
  endtask
  // Reset in mid-run clears hold, settings and delay lines
  task automatic t_reset();
    pwm = 3'h6;
    wr(3'h3, 8'h09);
    chk(dead_time, 8'h09);
    hold_set = 1'b1;
    cyc(1);
    hold_set = 1'b0;
    reset = 1'b1;
    cyc(3);
    reset = 1'b0;
    chk({status, 1'b0, phase_out}, 8'h3f);
    chk({dead_time, 1'b0, divider}, 8'h00);
    cyc(2);
    chk({2'h0, phase_out}, pat(3'h6));
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(3);
    reset = 1'b0;
    chk({status, 1'b0, phase_out}, 8'h3f);
    chk({dead_time, 1'b0, divider}, 8'h00);
    t_regs();
    inhibit = 1'b0;
    t_zero();
    t_inh_hold();
    t_dead();
    t_reset();
    chk(8'(shoots != 0), 8'h00);
    finish_test();
  end
endmodule // tb
